// file: hdl/spcl_loader.v
// Switch port configuration loader: applies stored words to per-port config fields
//
// Summary of operation
// - Port 3 de-emphasis select at F0h bit 6 takes bit 12 of word 46h.
// - Port 3 compliance-to-detect at 78h bit 11 takes bit 13 of word 46h.
// - Port 3 data change count select at 8Ch bits 9:8 takes bits 15:14 of word 46h.
// - Words 50h/52h/54h/56h bit 0 go to bit 3 of 44h of ports 0 to 3 (skip state reset).
// - Bits 3:1 of each port's power management word go to 40h bits 24:22 (aux current).
// - 40h bit 25 reads as constant 1, reporting D1 support.
// - 40h bit 26 reads as constant 1, reporting D2 support.
// - Bits 7:6 of each port's power management word go to 40h bits 29:28 (wake support D2/D1).
// - Words 51h/53h/55h/57h bits 15:8 go to read-only 44h bits 31:24 of ports 0 to 3.
// - Word 60h bit 1 goes to port 0 D0h bit 28 (connector reference clock).
// - Word 60h bit 2 goes to port 0 40h bit 21 (device-specific init required).
// - Word 60h bit 3 goes to port 0 144h bit 4 (VC1 is the low priority channel).
// - Word 62h bit 0 goes to port 1 C0h bit 24 (slot implemented).
`timescale 1ns/1ps
`default_nettype none
`include "spcl_regs.vh"

module spcl_loader (
   // Clock, reset and enable
   input wire clk,
   input wire rst,
   input wire ce,
   // Words delivered by the configuration memory reader
   input wire word_valid,
   input wire [7:0] word_addr,
   input wire [15:0] word_data,
   input wire load_end,
   // Configuration read port
   input wire cfg_rd,
   input wire [1:0] cfg_port,
   input wire [11:0] cfg_offset,
   output reg [31:0] cfg_rdata_q,
   output reg cfg_rvalid_q,
   output reg cfg_ready_q
);

   // ------------------------------------------------------------
   // Loader states
   // ------------------------------------------------------------
   localparam [1:0] ST_LOAD = 2'b00;
   localparam [1:0] ST_DONE = 2'b01;

   reg [1:0] state_q;

   // Per-port power management fields, indexed by port
   reg [2:0] aux_cur_q [0:3];
   reg [1:0] pme_sup_q [0:3];
   reg no_soft_rst_q [0:3];
   reg [7:0] pm_data_q [0:3];

   // Port specific fields
   reg deemph_p3_q;
   reg compl_p3_q;
   reg [1:0] dccs_p3_q;
   reg slot_clk_p0_q;
   reg dsi_p0_q;
   reg low_priority_channel_count_p0_q;
   reg slot_impl_p1_q;

   reg [31:0] rdata_d;
   integer i;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Power management words come in pairs per port, from 50h upward
   function pm_word_hit;
      input [7:0] addr;
      begin
         pm_word_hit = (addr >= `SPCL_WA_PM_BASE) && (addr <= `SPCL_WA_PM_LAST);
      end
   endfunction

   function [1:0] pm_word_port;
      input [7:0] addr;
      reg [7:0] rel;
      begin
         rel = addr - `SPCL_WA_PM_BASE;
         pm_word_port = rel[2:1];
      end
   endfunction

   wire take_word = (state_q == ST_LOAD) && word_valid;
   wire [1:0] pm_port = pm_word_port(word_addr);

   // ------------------------------------------------------------
   // Loader sequence
   // ------------------------------------------------------------
   always @(posedge clk) begin
      if (rst) begin
         state_q <= ST_LOAD;
         cfg_ready_q <= 1'b0;
      end else if (ce) begin
         case (state_q)
            ST_LOAD: begin
               // A word in the same cycle as the end marker is still applied
               if (load_end) begin
                  state_q <= ST_DONE;
                  cfg_ready_q <= 1'b1;
               end
            end
            ST_DONE: begin
               cfg_ready_q <= 1'b1;
            end
            default: begin
               state_q <= ST_LOAD;
               cfg_ready_q <= 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // Field loading
   // ------------------------------------------------------------
   always @(posedge clk) begin
      if (rst) begin
         for (i = 0; i < 4; i = i + 1) begin
            aux_cur_q[i] <= `SPCL_RST_AUX;
            pme_sup_q[i] <= `SPCL_RST_PME;
            no_soft_rst_q[i] <= `SPCL_RST_BIT;
            pm_data_q[i] <= `SPCL_RST_PM_DATA;
         end
         deemph_p3_q <= `SPCL_RST_BIT;
         compl_p3_q <= `SPCL_RST_BIT;
         dccs_p3_q <= `SPCL_RST_DCCS;
         slot_clk_p0_q <= `SPCL_RST_BIT;
         dsi_p0_q <= `SPCL_RST_BIT;
         low_priority_channel_count_p0_q <= `SPCL_RST_BIT;
         slot_impl_p1_q <= `SPCL_RST_BIT;
      end else if (ce && take_word) begin
         // Unlisted word addresses are ignored so fields keep reset values
         if (word_addr == `SPCL_WA_PORT3_PHY) begin
            deemph_p3_q <= word_data[`SPCL_WB_DEEMPH];
            compl_p3_q <= word_data[`SPCL_WB_COMPL];
            dccs_p3_q <= word_data[`SPCL_WB_DCCS_HI:`SPCL_WB_DCCS_LO];
         end else if (pm_word_hit(word_addr) && !word_addr[0]) begin
            no_soft_rst_q[pm_port] <= word_data[`SPCL_WB_NO_SOFT_RST];
            aux_cur_q[pm_port] <= word_data[`SPCL_WB_AUX_HI:`SPCL_WB_AUX_LO];
            // Bits 5:4 are not stored: D1/D2 support is fixed at one
            pme_sup_q[pm_port] <= word_data[`SPCL_WB_PME_HI:`SPCL_WB_PME_LO];
         end else if (pm_word_hit(word_addr)) begin
            pm_data_q[pm_port] <= word_data[`SPCL_WB_PM_DATA_HI:`SPCL_WB_PM_DATA_LO];
         end else if (word_addr == `SPCL_WA_PORT0_MISC) begin
            slot_clk_p0_q <= word_data[`SPCL_WB_SLOT_CLK];
            dsi_p0_q <= word_data[`SPCL_WB_DSI];
            low_priority_channel_count_p0_q <= word_data[`SPCL_WB_LOW_PRI_CNT];
         end else if (word_addr == `SPCL_WA_PORT1_MISC) begin
            slot_impl_p1_q <= word_data[`SPCL_WB_SLOT_IMPL];
         end
      end
   end

   // ------------------------------------------------------------
   // Configuration read decode
   // ------------------------------------------------------------
   // Only the loaded fields are modelled; all other bits read as zero except 40h bits 26:25 (D1/D2 support), which read as one
   always @* begin
      rdata_d = 32'h00000000;
      if (cfg_offset == `SPCL_OFF_PM_CAP) begin
         rdata_d[`SPCL_RB_AUX_LO +: 3] = aux_cur_q[cfg_port];
         rdata_d[`SPCL_RB_D1_SUP] = 1'b1;
         rdata_d[`SPCL_RB_D2_SUP] = 1'b1;
         rdata_d[`SPCL_RB_PME_LO +: 2] = pme_sup_q[cfg_port];
         if (cfg_port == 2'h0) begin
            rdata_d[`SPCL_RB_DSI] = dsi_p0_q;
         end
      end else if (cfg_offset == `SPCL_OFF_PM_CTL_DATA) begin
         rdata_d[`SPCL_RB_NO_SOFT_RST] = no_soft_rst_q[cfg_port];
         rdata_d[`SPCL_RB_PM_DATA_LO +: 8] = pm_data_q[cfg_port];
      end else if (cfg_offset == `SPCL_OFF_LINK_PHY_CTL) begin
         if (cfg_port == 2'h3) begin
            rdata_d[`SPCL_RB_COMPL] = compl_p3_q;
         end
      end else if (cfg_offset == `SPCL_OFF_PHY_CHG_CNT) begin
         if (cfg_port == 2'h3) begin
            rdata_d[`SPCL_RB_DCCS_LO +: 2] = dccs_p3_q;
         end
      end else if (cfg_offset == `SPCL_OFF_SLOT_CAP) begin
         if (cfg_port == 2'h1) begin
            rdata_d[`SPCL_RB_SLOT_IMPL] = slot_impl_p1_q;
         end
      end else if (cfg_offset == `SPCL_OFF_SLOT_CLK) begin
         if (cfg_port == 2'h0) begin
            rdata_d[`SPCL_RB_SLOT_CLK] = slot_clk_p0_q;
         end
      end else if (cfg_offset == `SPCL_OFF_DEEMPH_CTL) begin
         if (cfg_port == 2'h3) begin
            rdata_d[`SPCL_RB_DEEMPH] = deemph_p3_q;
         end
      end else if (cfg_offset == `SPCL_OFF_VC_CAP) begin
         if (cfg_port == 2'h0) begin
            rdata_d[`SPCL_RB_LOW_PRI_CNT] = low_priority_channel_count_p0_q;
         end
      end
   end

   // ------------------------------------------------------------
   // Read response
   // ------------------------------------------------------------
   // Reads before loading completes are dropped so no stale default leaks out
   always @(posedge clk) begin
      if (rst) begin
         cfg_rdata_q <= 32'h00000000;
         cfg_rvalid_q <= 1'b0;
      end else if (ce) begin
         cfg_rvalid_q <= cfg_rd && cfg_ready_q;
         if (cfg_rd && cfg_ready_q) begin
            cfg_rdata_q <= rdata_d;
         end
      end
   end

endmodule
`default_nettype wire

// file: pkg/spcl_regs.vh
// Offsets, field positions and reset values of the switch port configuration loader
`ifndef SPCL_REGS_VH
`define SPCL_REGS_VH

// ------------------------------------------------------------
// Configuration space offsets
// ------------------------------------------------------------
`define SPCL_OFF_PM_CAP 12'h040
`define SPCL_OFF_PM_CTL_DATA 12'h044
`define SPCL_OFF_LINK_PHY_CTL 12'h078
`define SPCL_OFF_PHY_CHG_CNT 12'h08C
`define SPCL_OFF_SLOT_CAP 12'h0C0
`define SPCL_OFF_SLOT_CLK 12'h0D0
`define SPCL_OFF_DEEMPH_CTL 12'h0F0
`define SPCL_OFF_VC_CAP 12'h144

// ------------------------------------------------------------
// Configuration memory word addresses
// ------------------------------------------------------------
`define SPCL_WA_PORT3_PHY 8'h46
`define SPCL_WA_PM_BASE 8'h50
`define SPCL_WA_PM_LAST 8'h57
`define SPCL_WA_PORT0_MISC 8'h60
`define SPCL_WA_PORT1_MISC 8'h62

// ------------------------------------------------------------
// Memory word bit positions
// ------------------------------------------------------------
`define SPCL_WB_DEEMPH 12
`define SPCL_WB_COMPL 13
`define SPCL_WB_DCCS_HI 15
`define SPCL_WB_DCCS_LO 14
`define SPCL_WB_NO_SOFT_RST 0
`define SPCL_WB_AUX_HI 3
`define SPCL_WB_AUX_LO 1
`define SPCL_WB_PME_HI 7
`define SPCL_WB_PME_LO 6
`define SPCL_WB_PM_DATA_HI 15
`define SPCL_WB_PM_DATA_LO 8
`define SPCL_WB_SLOT_CLK 1
`define SPCL_WB_DSI 2
`define SPCL_WB_LOW_PRI_CNT 3
`define SPCL_WB_SLOT_IMPL 0

// ------------------------------------------------------------
// Configuration register bit positions
// ------------------------------------------------------------
`define SPCL_RB_DEEMPH 6
`define SPCL_RB_COMPL 11
`define SPCL_RB_DCCS_LO 8
`define SPCL_RB_NO_SOFT_RST 3
`define SPCL_RB_DSI 21
`define SPCL_RB_AUX_LO 22
`define SPCL_RB_D1_SUP 25
`define SPCL_RB_D2_SUP 26
`define SPCL_RB_PME_LO 28
`define SPCL_RB_PM_DATA_LO 24
`define SPCL_RB_SLOT_CLK 28
`define SPCL_RB_LOW_PRI_CNT 4
`define SPCL_RB_SLOT_IMPL 24

// ------------------------------------------------------------
// Reset values of loaded fields
// ------------------------------------------------------------
`define SPCL_RST_BIT 1'b0
`define SPCL_RST_AUX 3'h0
`define SPCL_RST_PME 2'h0
`define SPCL_RST_DCCS 2'h0
`define SPCL_RST_PM_DATA 8'h00

`endif

// file: test/spcl_loader_assertions.sv
// Port-level checks for the switch port configuration loader
`timescale 1ns/1ps
`default_nettype none
module spcl_loader_checker (
   // Clock and control
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // Word port
   input wire logic word_valid,
   input wire logic [7:0] word_addr,
   input wire logic [15:0] word_data,
   input wire logic load_end,
   // Read port
   input wire logic cfg_rd,
   input wire logic [1:0] cfg_port,
   input wire logic [11:0] cfg_offset,
   input wire logic [31:0] cfg_rdata_q,
   input wire logic cfg_rvalid_q,
   input wire logic cfg_ready_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_read_answered: assert property (ce && cfg_rd && cfg_ready_q |=> cfg_rvalid_q)
      else $error("accepted read got no answer");
   a_early_read_refused: assert property (ce && cfg_rd && !cfg_ready_q |=> !cfg_rvalid_q)
      else $error("read answered before load end");
   a_rvalid_cause: assert property (cfg_rvalid_q && $past(ce) |-> $past(cfg_rd && cfg_ready_q))
      else $error("answer without accepted read");
   a_ready_sticky: assert property (cfg_ready_q |=> cfg_ready_q)
      else $error("ready dropped");
   a_ready_after_end: assert property (ce && load_end |=> cfg_ready_q)
      else $error("ready missing after load end");
   a_no_early_ready: assert property (!cfg_ready_q && !load_end |=> !cfg_ready_q)
      else $error("ready rose without load end");
   a_data_holds: assert property (!cfg_rvalid_q |-> $stable(cfg_rdata_q))
      else $error("read data changed without a read");
   a_pm_states_one: assert property (cfg_rvalid_q && $past(cfg_offset) == 12'h040
      |-> cfg_rdata_q[26:25] == 2'b11)
      else $error("power state support bits not one");
   a_dsi_port_only: assert property (cfg_rvalid_q && $past(cfg_offset) == 12'h040
      && $past(cfg_port) != 2'h0 |-> !cfg_rdata_q[21])
      else $error("init flag on wrong port");
   a_deemph_port_only: assert property (cfg_rvalid_q && $past(cfg_offset) == 12'h0F0
      && $past(cfg_port) != 2'h3 |-> cfg_rdata_q == 32'h0)
      else $error("de-emphasis on wrong port");
endmodule
bind spcl_loader spcl_loader_checker chk_u (.clk(clk), .rst(rst), .ce(ce),
   .word_valid(word_valid), .word_addr(word_addr), .word_data(word_data),
   .load_end(load_end), .cfg_rd(cfg_rd), .cfg_port(cfg_port), .cfg_offset(cfg_offset),
   .cfg_rdata_q(cfg_rdata_q), .cfg_rvalid_q(cfg_rvalid_q), .cfg_ready_q(cfg_ready_q));
`default_nettype wire

// file: test/spcl_loader_tb.sv
// Self-checking testbench of the switch port configuration loader
`timescale 1ns/1ps
`default_nettype none
module spcl_loader_tb;
   logic clk = 1'b0, rst = 1'b1, ce = 1'b1, cfg_rd = 1'b0;
   logic [1:0] cfg_port = 2'h0;
   logic [11:0] cfg_offset = 12'h000;
   logic word_valid, load_end, cfg_rvalid_q, cfg_ready_q;
   logic [7:0] word_addr;
   logic [15:0] word_data;
   logic [31:0] cfg_rdata_q;
   int num_errors = 0, check_count = 0;
   logic [11:0] offs [9] = '{12'h040, 12'h044, 12'h078, 12'h08C, 12'h0C0,
      12'h0D0, 12'h0F0, 12'h144, 12'h100};
   initial forever #5 clk = ~clk;
   spcl_mem_model mem_u (.clk(clk), .rst(rst), .word_valid(word_valid),
      .word_addr(word_addr), .word_data(word_data), .load_end(load_end));
   spcl_loader dut_u (.clk(clk), .rst(rst), .ce(ce), .word_valid(word_valid),
      .word_addr(word_addr), .word_data(word_data), .load_end(load_end),
      .cfg_rd(cfg_rd), .cfg_port(cfg_port), .cfg_offset(cfg_offset),
      .cfg_rdata_q(cfg_rdata_q), .cfg_rvalid_q(cfg_rvalid_q), .cfg_ready_q(cfg_ready_q));
   // Expected read word; everything not loaded reads as zero except 40h bits 26:25, which read as one
   function logic [31:0] ev(input logic [1:0] p, input logic [11:0] o);
      logic [15:0] f, d, m3, m0, m1;
      f = mem_u.mem[8'h50 + {p, 1'b0}];
      d = mem_u.mem[8'h51 + {p, 1'b0}];
      m3 = mem_u.mem[8'h46];
      m0 = mem_u.mem[8'h60];
      m1 = mem_u.mem[8'h62];
      case (o)
         12'h040: ev = {2'h0, f[7:6], 1'b0, 2'h3, f[3:1], p == 2'h0 && m0[2], 21'h0};
         12'h044: ev = {d[15:8], 20'h0, f[0], 3'h0};
         12'h078: ev = {20'h0, p == 2'h3 && m3[13], 11'h0};
         12'h08C: ev = {22'h0, (p == 2'h3) ? m3[15:14] : 2'h0, 8'h00};
         12'h0C0: ev = {7'h00, p == 2'h1 && m1[0], 24'h0};
         12'h0D0: ev = {3'h0, p == 2'h0 && m0[1], 28'h0};
         12'h0F0: ev = {25'h0, p == 2'h3 && m3[12], 6'h00};
         12'h144: ev = {27'h0, p == 2'h0 && m0[3], 4'h0};
         default: ev = 32'h0;
      endcase
   endfunction
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", n, e, s);
      end
   endtask
   task rd(input logic [1:0] p, input logic [11:0] o, input logic acc);
      @(posedge clk);
      cfg_rd <= 1'b1;
      cfg_port <= p;
      cfg_offset <= o;
      @(posedge clk);
      cfg_rd <= 1'b0;
      #1;
      chk("rvalid", {31'h0, cfg_rvalid_q}, {31'h0, acc});
      if (acc) chk("rdata", cfg_rdata_q, ev(p, o));
   endtask
   task report_and_stop();
      if (num_errors == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd(2'h0, 12'h040, 1'b0);
      repeat (200) if (cfg_ready_q !== 1'b1) @(posedge clk);
      chk("ready", {31'h0, cfg_ready_q}, 32'h1);
      for (int p = 0; p < 4; p++)
         for (int k = 0; k < 9; k++) rd(2'(p), offs[k], 1'b1);
      // Clock enable low freezes the read port, so the request is never seen
      @(posedge clk);
      ce <= 1'b0;
      rd(2'h3, 12'h0F0, 1'b0);
      chk("frozen rdata", cfg_rdata_q, 32'h0);
      @(posedge clk);
      ce <= 1'b1;
      report_and_stop();
   end
   initial begin
      repeat (3000) @(posedge clk);
      num_errors++;
      report_and_stop();
   end
endmodule
`default_nettype wire

// file: test/spcl_mem_model.sv
// Configuration memory model streaming words to the loader
`timescale 1ns/1ps
`default_nettype none
module spcl_mem_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Word stream
   output logic word_valid = 1'b0,
   output logic [7:0] word_addr = 8'h00,
   output logic [15:0] word_data = 16'h0000,
   output logic load_end = 1'b0
);
   logic [15:0] mem [0:255];
   logic [6:0] idx;
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 16'(i * 40503) ^ 16'h5A3C;
      // Loaded bits set so each field differs from its reset value on some port
      mem[8'h46] = 16'hB936;
      mem[8'h52] = 16'hF7A3;
      mem[8'h54] = 16'hB0CB;
      mem[8'h60] = 16'h0E9E;
      mem[8'h62] = 16'hCB33;
   end
   // Walks 40h..6Fh, unlisted words too; one stale word follows the end mark
   always @(posedge clk) begin
      if (rst) begin
         idx <= 7'h00;
         word_valid <= 1'b0;
         load_end <= 1'b0;
      end else begin
         word_valid <= idx < 7'd48 || idx == 7'd49;
         load_end <= idx == 7'd48;
         if (idx < 7'd48) begin
            word_addr <= 8'h40 + 8'(idx);
            word_data <= mem[8'h40 + 8'(idx)];
         end else if (idx == 7'd49) begin
            word_addr <= 8'h50;
            word_data <= ~mem[8'h50];
         end else begin
            // Idle bus shows no stale value
            word_addr <= ~word_addr;
            word_data <= ~word_data;
         end
         if (idx < 7'd50) idx <= idx + 7'd1;
      end
   end
endmodule
`default_nettype wire
